/* logic/dual_mode_pins.sv */
// Dual-function pin decoder: host-mode sync and line pins, strap-mode straps
`timescale 1ns/100ps
module dual_mode_pins #(
  parameter int LINES = pin_mux_pkg::NUM_LINE_PINS
) (
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  input  wire logic [1:0]                             mode_select_pin,
  input  wire logic                                   common_frame_start,
  input  wire logic [LINES-1:0]                       line_ctl_pin_in,
  output logic      [LINES-1:0]                       line_ctl_pin_out,
  output logic      [LINES-1:0]                       line_ctl_pin_oe,
  input  wire logic [LINES-1:0]                       pin_direction,
  input  wire logic [pin_mux_pkg::SETUP_WIDTH-1:0]    setup_register,
  input  wire logic [2*pin_mux_pkg::OFFSET_WIDTH-1:0] frame_offset_register,
  input  wire logic [LINES-1:0]                       line_out_value,
  output logic      [LINES-1:0]                       line_in_value,
  output logic      [pin_mux_pkg::NUM_CHANNELS-1:0]   line_select_out_n,
  output logic                                        rx_frame_start,
  output logic                                        tx_frame_start,
  output logic      [2:0]                             strap_frame_start,
  output logic      [1:0]                             rx_gain_high,
  output logic      [1:0]                             powerdown,
  output logic      [1:0]                             mode
);
  localparam int SW = LINES + 3;
  localparam int OW = pin_mux_pkg::OFFSET_WIDTH;
  localparam int CW = pin_mux_pkg::CS_CNT_WIDTH;
  localparam logic [CW-1:0] CS_LAST = CW'(pin_mux_pkg::CS_PERIOD_CYC - 1);
  localparam logic [CW-1:0] CS_SLOT = CW'(pin_mux_pkg::CS_PERIOD_CYC / 4);

  typedef struct packed {
    pin_mux_pkg::mode_type mode;
    logic [2:0]            sync_prev;
    logic [2:0]            strap_start;
    logic [1:0]            gain;
    logic [1:0]            pd;
    logic [CW-1:0]         cs_cnt;
    logic [LINES-1:0]      in_val;
    logic [LINES-1:0]      out_val;
    logic [3:0]            sel_n;
    logic                  host_start;
  } state_type;
  state_type state_q;
  state_type state_d;

  logic                  rx_delayed;
  logic                  tx_delayed;
  logic                  dynamic;
  logic [SW-1:0]         synced;
  logic [LINES-1:0]      pins_s;
  logic                  sync_s;
  logic [1:0]            mode_s;
  logic [2:0]            sync_now;

  strap_bus_if #(.WIDTH(SW)) strap_bus ();
  assign strap_bus.raw = {mode_select_pin, common_frame_start, line_ctl_pin_in};

  // Straps and pins settle through two flops before anything decodes them
  level_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .bus  (strap_bus)  // [RQ13]
  );
  assign synced = strap_bus.synced;
  assign pins_s = synced[LINES-1:0];
  assign sync_s = synced[LINES];
  assign mode_s = synced[LINES+2:LINES+1];
  assign dynamic = setup_register[pin_mux_pkg::SETUP_DYN_BIT];
  assign sync_now = {pins_s[pin_mux_pkg::PIN_SYNC_CH2],
                     pins_s[pin_mux_pkg::PIN_SYNC_CH1], sync_s};

  always_comb begin
    state_d = state_q;
    unique case (mode_s)  // [RQ11]
      pin_mux_pkg::MODE_SEL_STRAP: state_d.mode = pin_mux_pkg::MODE_STRAP;
      pin_mux_pkg::MODE_SEL_HOST:  state_d.mode = pin_mux_pkg::MODE_HOST;
      default:                     state_d.mode = pin_mux_pkg::MODE_RESET;
    endcase
    state_d.sync_prev   = sync_now;
    state_d.strap_start = '0;
    state_d.host_start  = 1'b0;
    state_d.gain        = '0;
    state_d.pd          = '0;
    state_d.sel_n       = 4'hf;
    unique case (state_q.mode)
      pin_mux_pkg::MODE_STRAP: begin
        // Falling edge of a one-cycle pulse; transfer follows in next slot
        state_d.strap_start = state_q.sync_prev & ~sync_now;  // [RQ3] [RQ4]
        state_d.gain[0] = pins_s[pin_mux_pkg::PIN_GAIN_CH2];  // [RQ7]
        state_d.pd[0]   = pins_s[pin_mux_pkg::PIN_PD_CH2];    // [RQ8]
        state_d.gain[1] = pins_s[pin_mux_pkg::PIN_GAIN_CH3];  // [RQ9]
        state_d.pd[1]   = pins_s[pin_mux_pkg::PIN_PD_CH3];    // [RQ10]
        state_d.cs_cnt  = '0;
      end
      pin_mux_pkg::MODE_HOST: begin
        // Rising edge works for both pulse and square wave syncs
        state_d.host_start = sync_s & ~state_q.sync_prev[0];  // [RQ1]
        state_d.pd[0] = setup_register[pin_mux_pkg::SETUP_OFF2_BIT];
        state_d.pd[1] = setup_register[pin_mux_pkg::SETUP_OFF3_BIT];
        state_d.cs_cnt = (state_q.cs_cnt == CS_LAST) ? '0 : state_q.cs_cnt + 1'b1;
        if (dynamic) begin  // [RQ6]
          // Four selects share the period; pins move only while one is low
          for (int i = 0; i < 4; i++) begin
            state_d.sel_n[i] = !(state_q.cs_cnt == CW'(i) * CS_SLOT);
          end
          if (state_q.sel_n != 4'hf) begin
            state_d.in_val  = pins_s;
          end
          if (state_d.sel_n != 4'hf) begin
            state_d.out_val = line_out_value;
          end
        end else begin
          state_d.in_val  = pins_s;
          state_d.out_val = line_out_value;
        end
      end
      default: begin
        state_d.cs_cnt  = '0;
        state_d.in_val  = '0;
        state_d.out_val = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '{mode: pin_mux_pkg::MODE_RESET, sel_n: 4'hf, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // Master clock is the bit clock, so offsets count clk cycles
  frame_offset_delay #(.WIDTH(OW)) u_rx_delay (
    .clk       (clk),
    .nrst      (nrst),
    .start_in  (state_q.host_start),
    .offset    (frame_offset_register[OW-1:0]),
    .start_out (rx_delayed)  // [RQ12]
  );
  frame_offset_delay #(.WIDTH(OW)) u_tx_delay (
    .clk       (clk),
    .nrst      (nrst),
    .start_in  (state_q.host_start),
    .offset    (frame_offset_register[2*OW-1:OW]),
    .start_out (tx_delayed)  // [RQ2]
  );

  assign rx_frame_start    = rx_delayed;
  assign tx_frame_start    = tx_delayed;
  assign strap_frame_start = state_q.strap_start;
  assign rx_gain_high      = state_q.gain;
  assign powerdown         = state_q.pd;
  assign mode              = state_q.mode;
  assign line_in_value     = state_q.in_val;
  assign line_select_out_n = state_q.sel_n;
  assign line_ctl_pin_out  = state_q.out_val;
  // Pins drive only in host mode; straps are always inputs
  assign line_ctl_pin_oe   = (state_q.mode == pin_mux_pkg::MODE_HOST) ?
                             pin_direction : '0;  // [RQ5]
endmodule : dual_mode_pins

/* logic/pin_mux_pkg.sv */
// Constants and types shared by the dual-mode pin block
// Overview of operation
// [RQ1] Host mode: 8 kHz pulse on common sync marks rx and tx frame start.
// [RQ2] Rx and tx frame starts each delayed 0 to 7 bit clocks by offset register.
// [RQ3] Strap mode: common sync is channel 0 sync, one cycle, starts after fall.
// [RQ4] Strap mode: line pins 4 and 5 are channel 1 and 2 syncs, same timing.
// [RQ5] Host mode: each line pin direction follows its direction register bit.
// [RQ6] Setup register picks static pins or dynamic pins synced to chip selects.
// [RQ7] Strap mode: channel 2 gain strap high gives -0.8 dB, low -4.3 dB.
// [RQ8] Strap mode: channel 2 power-down strap high powers channel down like setup bit2.
// [RQ9] Strap mode: line pin 2 is channel 3 gain strap, same settings.
// [RQ10] Strap mode: line pin 3 is channel 3 power-down strap, same decode.
// [RQ11] Two mode pins select strap, host or reset; mode sets every pin function.
// [RQ12] Master clock doubles as the PCM bit clock for all frame timing.
// [RQ13] Strap levels are synchronised to the master clock before decoding.
package pin_mux_pkg;
  localparam int NUM_LINE_PINS  = 6;
  localparam int NUM_CHANNELS   = 4;
  localparam int OFFSET_WIDTH   = 3;
  localparam int SYNC_STAGES    = 2;
  localparam int SETUP_WIDTH    = 8;
  localparam int SETUP_DYN_BIT  = 0;
  localparam int SETUP_OFF2_BIT = 2;
  localparam int SETUP_OFF3_BIT = 3;
  localparam int PIN_GAIN_CH2   = 0;
  localparam int PIN_PD_CH2     = 1;
  localparam int PIN_GAIN_CH3   = 2;
  localparam int PIN_PD_CH3     = 3;
  localparam int PIN_SYNC_CH1   = 4;
  localparam int PIN_SYNC_CH2   = 5;
  // Chip-select repetition 31.25 us at 8 ns clock
  localparam int CS_PERIOD_NS   = 31250;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CS_PERIOD_CYC  = CS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CS_CNT_WIDTH   = 12;
  localparam logic [1:0] MODE_SEL_STRAP = 2'h1;
  localparam logic [1:0] MODE_SEL_HOST  = 2'h2;
  localparam logic [1:0] MODE_SEL_RESET = 2'h0;
  localparam logic [NUM_LINE_PINS-1:0] DIR_RESET   = 6'h00;
  localparam logic [SETUP_WIDTH-1:0]   SETUP_RESET = 8'h00;
  typedef enum logic [1:0] {MODE_RESET, MODE_STRAP, MODE_HOST} mode_type;
  // Gain code: 1 selects -0.8 dB, 0 selects -4.3 dB
  typedef enum logic {GAIN_M4P3_DB, GAIN_M0P8_DB} gain_type;
endpackage : pin_mux_pkg

/* logic/strap_bus_if.sv */
// Carrier for synchronised pin levels between the pin modules
`timescale 1ns/100ps
interface strap_bus_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport source (output raw, input synced);
  modport sync   (input raw, output synced);
endinterface : strap_bus_if

/* logic/level_sync.sv */
// Two-stage synchroniser for strap and pin levels
`timescale 1ns/100ps
module level_sync (
  input  wire logic clk,
  input  wire logic nrst,
  strap_bus_if.sync bus
);
  typedef struct packed {
    logic [$bits(bus.raw)-1:0] first;
    logic [$bits(bus.raw)-1:0] second;
  } state_type;
  state_type state_q;
  state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.first  = bus.raw;
    state_d.second = state_q.first;  // [RQ13]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign bus.synced = state_q.second;
endmodule : level_sync

/* logic/frame_offset_delay.sv */
// Per-direction programmable frame-start delay of 0 to 7 bit clocks
`timescale 1ns/100ps
module frame_offset_delay #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] offset,
  output logic                  start_out
);
  typedef struct packed {
    logic [(1<<WIDTH)-1:0] taps;
    logic                  start;
  } state_type;
  state_type state_q;
  state_type state_d;

  always_comb begin
    state_d       = state_q;
    state_d.taps  = {state_q.taps[(1<<WIDTH)-2:0], start_in};
    state_d.start = state_d.taps[offset];  // [RQ2]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign start_out = state_q.start;
endmodule : frame_offset_delay

/* bench/dual_mode_pins_monitor.sv */
// Port-level checks for the dual-mode pin decoder
`timescale 1ns/100ps
module dual_mode_pins_monitor #(
  parameter int LINES = pin_mux_pkg::NUM_LINE_PINS
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic [1:0]       mode_select_pin,
  input wire logic             common_frame_start,
  input wire logic [LINES-1:0] line_ctl_pin_in,
  input wire logic [LINES-1:0] line_ctl_pin_oe,
  input wire logic [LINES-1:0] pin_direction,
  input wire logic [7:0]       setup_register,
  input wire logic [3:0]       line_select_out_n,
  input wire logic             rx_frame_start,
  input wire logic [2:0]       strap_frame_start,
  input wire logic [1:0]       rx_gain_high,
  input wire logic [1:0]       powerdown,
  input wire logic [1:0]       mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_reset_quiet: assert property (
    (mode_select_pin == 2'h0)[*6] |-> line_ctl_pin_oe == '0 && strap_frame_start == 3'h0)
    else $error("outputs active in reset mode");
  chk_host_dir: assert property (
    (mode_select_pin == 2'h2 && $stable(pin_direction))[*6] |-> line_ctl_pin_oe == pin_direction)
    else $error("pin enable differs from direction");
  chk_strap_gain: assert property (
    (mode_select_pin == 2'h1 && $stable(line_ctl_pin_in[3:0]))[*6]
    |-> rx_gain_high == {line_ctl_pin_in[2], line_ctl_pin_in[0]}) else $error("gain strap wrong");
  chk_strap_pd: assert property (
    (mode_select_pin == 2'h1 && $stable(line_ctl_pin_in[3:0]))[*6]
    |-> powerdown == {line_ctl_pin_in[3], line_ctl_pin_in[1]}) else $error("pd strap wrong");
  chk_sync0_start: assert property (
    mode == 2'h1 && $fell(common_frame_start) |-> ##[3:5] strap_frame_start[0])
    else $error("channel 0 start missing");
  chk_sync1_start: assert property (
    mode == 2'h1 && $fell(line_ctl_pin_in[4]) |-> ##[3:5] strap_frame_start[1])
    else $error("channel 1 start missing");
  chk_sync2_start: assert property (
    mode == 2'h1 && $fell(line_ctl_pin_in[5]) |-> ##[3:5] strap_frame_start[2])
    else $error("channel 2 start missing");
  chk_host_start: assert property (
    mode == 2'h2 && $rose(common_frame_start) |-> ##[3:12] rx_frame_start ##1 !rx_frame_start)
    else $error("host frame start wrong");
  chk_select_idle: assert property (
    (mode_select_pin != 2'h2 || !setup_register[0])[*6] |-> line_select_out_n == 4'hf)
    else $error("chip select active in static mode");
endmodule : dual_mode_pins_monitor

bind dual_mode_pins dual_mode_pins_monitor #(.LINES(LINES)) monitor (.clk, .nrst,
  .mode_select_pin, .common_frame_start, .line_ctl_pin_in, .line_ctl_pin_oe, .pin_direction,
  .setup_register, .line_select_out_n, .rx_frame_start, .strap_frame_start, .rx_gain_high,
  .powerdown, .mode);

/* bench/line_partner.sv */
// Far-side model: backplane sync source and line devices
`timescale 1ns/100ps
module line_partner (
  input  wire logic       clk,
  input  wire logic [2:0] pulse_req,
  input  wire logic [5:0] strap_level,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  output logic            frame_sync,
  output logic [5:0]      pin_in
);
  logic [2:0] pulse_q;
  // Syncs are one master clock wide
  always_ff @(posedge clk) pulse_q <= pulse_req;
  assign frame_sync = pulse_q[0];
  always_comb begin
    pin_in = strap_level | {pulse_q[2:1], 4'h0};
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
    end
  end
endmodule : line_partner

/* bench/dual_mode_pins_test.sv */
// Self-checking bench for the dual-mode pin decoder
`timescale 1ns/100ps
module dual_mode_pins_test;
  logic       clk = 1'b0, nrst = 1'b0, common_frame_start, rx_frame_start, tx_frame_start;
  logic [1:0] mode_select_pin = 2'h0, rx_gain_high, powerdown, mode;
  logic [5:0] line_ctl_pin_in, line_ctl_pin_out, line_ctl_pin_oe, line_in_value;
  logic [5:0] pin_direction = 6'h00, line_out_value = 6'h00, strap_level = 6'h00;
  logic [5:0] frame_offset_register = 6'h00;
  logic [7:0] setup_register = 8'h00;
  logic [3:0] line_select_out_n;
  logic [2:0] strap_frame_start, pulse_req = 3'h0, st_seen;
  int         failures = 0, comparisons = 0, cycles = 0, rx_at, tx_at, base_rx, base_tx;
  // Strap pins 3:0 and expected {powerdown, gain}
  logic [3:0] row_in [5] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h6};
  logic [3:0] row_exp [5] = '{4'h0, 4'h3, 4'hc, 4'hf, 4'h6};
  logic [5:0] offsets [3] = '{6'h07, 6'h2b, 6'h38};
  always #4 clk = ~clk;
  dual_mode_pins DUT (.clk, .nrst, .mode_select_pin, .common_frame_start, .line_ctl_pin_in,
    .line_ctl_pin_out, .line_ctl_pin_oe, .pin_direction, .setup_register,
    .frame_offset_register, .line_out_value, .line_in_value, .line_select_out_n,
    .rx_frame_start, .tx_frame_start, .strap_frame_start, .rx_gain_high, .powerdown, .mode);
  line_partner far_side (.clk, .pulse_req, .strap_level, .pin_out(line_ctl_pin_out),
    .pin_oe(line_ctl_pin_oe), .frame_sync(common_frame_start), .pin_in(line_ctl_pin_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic fire(input logic [2:0] which);
    rx_at = -1;
    tx_at = -1;
    st_seen = 3'h0;
    step(2);
    pulse_req = which;
    step(1);
    pulse_req = 3'h0;
    for (int i = 0; i < 20; i++) begin
      if (rx_frame_start === 1'b1 && rx_at < 0) rx_at = i;
      if (tx_frame_start === 1'b1 && tx_at < 0) tx_at = i;
      st_seen = st_seen | strap_frame_start;
      step(1);
    end
  endtask : fire
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    step(2);
    nrst = 1'b1;
    check({4'h0, line_select_out_n}, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      mode_select_pin = 2'(m);
      step(6);
      check({6'h0, mode}, (m == 3) ? 8'h00 : 8'(m));
    end
    mode_select_pin = 2'h1;
    for (int r = 0; r < 5; r++) begin
      strap_level = {2'h0, row_in[r]};
      step(6);
      check({4'h0, powerdown, rx_gain_high}, {4'h0, row_exp[r]});
      check({2'h0, line_ctl_pin_oe}, 8'h00);
    end
    for (int ch = 0; ch < 3; ch++) begin
      fire(3'(1 << ch));
      check({5'h0, st_seen}, 8'(1 << ch));
      check(8'(rx_at), 8'hff);
    end
    mode_select_pin = 2'h2;
    pin_direction = 6'h2d;
    line_out_value = 6'h19;
    strap_level = 6'h3f;
    setup_register = 8'h0c;
    step(6);
    check({2'h0, line_ctl_pin_oe}, 8'h2d);
    check({2'h0, line_ctl_pin_out & 6'h2d}, 8'h09);
    check({2'h0, line_in_value & 6'h12}, 8'h12);
    check({6'h0, powerdown}, 8'h03);
    fire(3'h1);
    base_rx = rx_at;
    base_tx = tx_at;
    check({7'h0, base_rx >= 0 && base_tx >= 0}, 8'h01);
    // Offsets measured against the zero-offset latency, not an absolute count
    for (int k = 0; k < 3; k++) begin
      frame_offset_register = offsets[k];
      fire(3'h1);
      check(8'(rx_at - base_rx), {5'h0, offsets[k][2:0]});
      check(8'(tx_at - base_tx), {5'h0, offsets[k][5:3]});
    end
    setup_register = 8'h01;
    line_out_value = 6'h24;
    // Dynamic pins keep their old drive until a select window opens
    for (int i = 0; i < 4000 && line_select_out_n === 4'hf; i++) begin
      check({2'h0, line_ctl_pin_out & 6'h2d}, 8'h09);
      step(1);
    end
    check({7'h0, $onehot(~line_select_out_n)}, 8'h01);
    check({2'h0, line_ctl_pin_out & 6'h2d}, 8'h24);
    step(1);
    check({4'h0, line_select_out_n}, 8'h0f);
    // Mid-run reset clears every decoded output, then host mode returns
    nrst = 1'b0;
    step(1);
    check({line_select_out_n, powerdown, rx_gain_high}, 8'hf0);
    check({2'h0, line_ctl_pin_out | line_ctl_pin_oe | line_in_value}, 8'h00);
    check({6'h0, rx_frame_start, tx_frame_start}, 8'h00);
    nrst = 1'b1;
    step(6);
    check({6'h0, mode}, 8'h02);
    check({2'h0, line_ctl_pin_oe}, 8'h2d);
    give_verdict();
  end
endmodule : dual_mode_pins_test
